// ===== hdl/ncs_csr_port.sv
// Summary of operation
// (R1) rx and tx each stopped, running or suspended
// (R2) state moves only on writes or events
// (R3) suspended rx resumes on recognized frame
// (R4) longword access, register x at 4x
// (R5) reserved, read-only, write-only, write-one-clear bits
// (R6) registers 0-7,15 physical, 8-14 virtual
// (R7) physical access completes in one cycle
// (R8) virtual service up to 20 us, bus free
// (R9) first virtual access drops done until complete
// (R10) host polls done before next virtual access
// (R11) virtual write completes now, captured later
// (R12) virtual read: invalid first, valid after done
// (R13) host writes vector register first
// (R14) host verifies vector write, clears parity flag
// (R15) priority field picks level 14 to 17
// (R16) bit 29 selects synchronous bus mastering
// (R17) ack cycle drives vector, other bits zero
// (R18) vector bits 1:0 fixed, writes ignored
// (R19) vector register resets to 1FFF0003
// (R20) tx poll write while suspended checks transmit list
// (R21) tx poll only when suspended, unreadable
// (R22) tx poll ignored when stopped or running
// (R23) rx poll write while suspended checks list
// (R24) init_done gates commands, processes stopped after
`default_nettype none
module ncs_csr_port
    import ncs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] bus_addr,
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic [31:0] bus_wdata,
    output logic [31:0] bus_rdata,
    output logic bus_ack,
    output logic bus_err,
    input wire logic int_ack,
    output logic [31:0] vector_data,
    output logic [4:0] int_level,
    output logic sync_master,
    input wire ncs_evt_t evt,
    output logic tx_poll_pulse,
    output logic rx_poll_pulse,
    output ncs_proc_t tx_state,
    output ncs_proc_t rx_state,
    output logic virt_req,
    output logic virt_wr,
    output logic [3:0] virt_num,
    output logic [31:0] virt_wdata,
    input wire logic [31:0] virt_rdata
);
    // request bundle from the host bus
    ncs_req_t req;
    assign req.sel = bus_sel;
    assign req.wr = bus_wr;
    assign req.num = bus_addr[ADDR_LSB+3:ADDR_LSB];
    assign req.wdata = bus_wdata;

    logic [31:0] vec_prio; // vector/priority/sync register
    logic init_done; // set after the init sequence
    logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt;
    logic done; // virtual access done flag
    logic parity_flag; // sticky parity error
    logic [$clog2(VIRT_CYCLES+1)-1:0] virt_cnt;
    logic [31:0] virt_hold; // captured virtual read data
    logic [3:0] virt_reg; // register being serviced
    logic rd_pend; // a finished virtual read waits for its second read

    // decode; misaligned addresses are refused
    wire aligned = (bus_addr[1:0] == 2'h0); // R4
    wire acc = req.sel && aligned;
    wire is_virt = (req.num >= REG_VIRT_FIRST) && (req.num <= REG_VIRT_LAST); // R6
    wire wr_vec = acc && req.wr && (req.num == REG_VEC_PRIO) && init_done;
    wire wr_tx = acc && req.wr && (req.num == REG_TX_POLL) && init_done;
    wire wr_rx = acc && req.wr && (req.num == REG_RX_POLL) && init_done;
    wire wr_stat = acc && req.wr && (req.num == REG_GLOBAL_STATUS);
    // the second read of the same register collects the result
    // and must not start a fresh service, or done would drop again
    wire collect = acc && !req.wr && is_virt && (req.num == virt_reg) && rd_pend && done; // R12
    // a virtual access starts service only while idle
    wire virt_start = acc && is_virt && done && init_done && !collect; // R9
    wire clr_parity = wr_stat && req.wdata[PARITY_BIT]; // R5
    wire tx_ok = wr_tx && (tx_state == NCS_SUSPENDED); // R22
    wire rx_ok = wr_rx && (rx_state == NCS_SUSPENDED); // R23

    // status word; read-only top, write-one-clear low
    wire [31:0] stat_word = {init_done, 14'h0, done, 7'h0, parity_flag, 8'h0};

    // read mux; poll registers are write-only and read zero
    wire [31:0] read_word =
        (req.num == REG_VEC_PRIO) ? vec_prio :
        (req.num == REG_GLOBAL_STATUS) ? stat_word :
        collect ? virt_hold : 32'h0; // R12

    // single-cycle answer for every register; virtual ones too
    assign bus_ack = acc; // R7 R11
    assign bus_err = req.sel && !aligned;
    assign bus_rdata = read_word;

    // interrupt acknowledge drives only the vector
    assign vector_data = int_ack ? {16'h0, vec_prio[15:2], 2'h0} : 32'h0; // R17
    assign int_level = IPL_BASE + {3'h0, vec_prio[PRIO_HI:PRIO_LO]}; // R15
    assign sync_master = vec_prio[SYNC_BIT]; // R16

    // any poll write with the right state checks the list
    assign tx_poll_pulse = tx_ok; // R20
    assign rx_poll_pulse = rx_ok; // R23

    // virtual request to the on-chip service engine
    assign virt_req = !done && (virt_cnt == '0);
    assign virt_num = virt_reg;

    // init sequence counter
    always_ff @(posedge clk) begin
        if (reset) begin
            init_cnt <= '0;
            init_done <= 1'b0;
        end else if (!init_done) begin
            init_cnt <= init_cnt + 1'b1;
            init_done <= (init_cnt == INIT_CYCLES[$bits(init_cnt)-1:0] - 1'b1); // R24
        end
    end

    // vector/priority register; fixed low bits survive writes
    always_ff @(posedge clk) begin
        if (reset) begin
            vec_prio <= VEC_PRIO_RESET; // R19
        end else if (wr_vec) begin
            // reserved bits keep their fixed reset pattern
            vec_prio <= (req.wdata & VEC_PRIO_WMASK) | (VEC_PRIO_RESET & ~VEC_PRIO_WMASK); // R5 R18
        end
    end

    // parity flag; a new error beats a simultaneous clear
    always_ff @(posedge clk) begin
        if (reset) begin
            parity_flag <= 1'b0;
        end else if (evt.parity_err) begin
            parity_flag <= 1'b1;
        end else if (clr_parity) begin
            parity_flag <= 1'b0; // R5
        end
    end

    // virtual access service: host bus is freed at once
    always_ff @(posedge clk) begin
        if (reset) begin
            done <= 1'b1;
            virt_cnt <= '0;
            virt_reg <= 4'h0;
            virt_wr <= 1'b0;
            virt_wdata <= 32'h0;
            virt_hold <= 32'h0;
            rd_pend <= 1'b0;
        end else if (virt_start) begin
            done <= 1'b0; // R9
            rd_pend <= 1'b0;
            virt_cnt <= '0;
            virt_reg <= req.num;
            virt_wr <= req.wr;
            virt_wdata <= req.wdata; // R11
        end else if (collect) begin
            // result handed over; next access is a new one
            rd_pend <= 1'b0; // R12
        end else if (!done) begin
            // completion within the service budget
            virt_cnt <= virt_cnt + 1'b1; // R8
            if (virt_cnt == VIRT_CYCLES[$bits(virt_cnt)-1:0] - 1'b1) begin
                done <= 1'b1; // R9
                rd_pend <= !virt_wr;
                virt_hold <= virt_wr ? virt_wdata : virt_rdata; // R12
            end
        end
    end

    // transmit process; commands ignored until init done
    always_ff @(posedge clk) begin
        if (reset || !init_done) begin
            tx_state <= NCS_STOPPED; // R24
        end else begin
            case (tx_state)
                NCS_STOPPED: if (evt.tx_start) tx_state <= NCS_RUNNING; // R2
                NCS_RUNNING: begin
                    if (evt.tx_stop) tx_state <= NCS_STOPPED;
                    else if (evt.tx_suspend) tx_state <= NCS_SUSPENDED;
                end
                NCS_SUSPENDED: begin
                    if (evt.tx_stop) tx_state <= NCS_STOPPED;
                    else if (tx_ok) tx_state <= NCS_RUNNING; // R20
                end
                default: tx_state <= NCS_STOPPED; // R1
            endcase
        end
    end

    // receive process; a recognized frame also resumes it
    always_ff @(posedge clk) begin
        if (reset || !init_done) begin
            rx_state <= NCS_STOPPED;
        end else begin
            case (rx_state)
                NCS_STOPPED: if (evt.rx_start) rx_state <= NCS_RUNNING;
                NCS_RUNNING: begin
                    if (evt.rx_stop) rx_state <= NCS_STOPPED;
                    else if (evt.rx_suspend) rx_state <= NCS_SUSPENDED;
                end
                NCS_SUSPENDED: begin
                    if (evt.rx_stop) rx_state <= NCS_STOPPED;
                    else if (rx_ok || evt.rx_frame) rx_state <= NCS_RUNNING; // R3
                end
                default: rx_state <= NCS_STOPPED; // R1
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== hdl/ncs_pkg.sv
`default_nettype none
package ncs_pkg;
    // register numbers; byte address is four times the number
    localparam logic [3:0] REG_VEC_PRIO = 4'h0;
    localparam logic [3:0] REG_TX_POLL = 4'h1;
    localparam logic [3:0] REG_RX_POLL = 4'h2;
    localparam logic [3:0] REG_GLOBAL_STATUS = 4'h5;
    localparam logic [3:0] REG_VIRT_FIRST = 4'h8;
    localparam logic [3:0] REG_VIRT_LAST = 4'hE;
    localparam int ADDR_LSB = 2;
    // vector/priority/sync register layout
    localparam logic [31:0] VEC_PRIO_RESET = 32'h1FFF0003;
    localparam int PRIO_HI = 31;
    localparam int PRIO_LO = 30;
    localparam int SYNC_BIT = 29;
    localparam logic [31:0] VEC_PRIO_WMASK = 32'hE000FFFC;
    localparam logic [1:0] VEC_FIXED_LOW = 2'h3;
    // interrupt levels selected by the priority field
    localparam logic [4:0] IPL_BASE = 5'h14;
    // global status layout
    localparam int INIT_DONE_BIT = 31;
    localparam int DONE_BIT = 16;
    localparam int PARITY_BIT = 8;
    // virtual service time
    localparam int VIRT_TIME_US = 20;
    localparam int CLK_MHZ = 25;
    localparam int VIRT_CYCLES = VIRT_TIME_US * CLK_MHZ;
    localparam int INIT_CYCLES = 16;
    typedef enum logic [1:0] {NCS_STOPPED, NCS_RUNNING, NCS_SUSPENDED} ncs_proc_t;
    // one host register access
    typedef struct packed {
        logic sel;
        logic wr;
        logic [3:0] num;
        logic [31:0] wdata;
    } ncs_req_t;
    // pulses from the datapath outside
    typedef struct packed {
        logic tx_start;
        logic tx_stop;
        logic tx_suspend;
        logic rx_start;
        logic rx_stop;
        logic rx_suspend;
        logic rx_frame;
        logic parity_err;
    } ncs_evt_t;
endpackage
`default_nettype wire

// ===== verification/ncs_csr_port_chk.sv
`default_nettype none
module ncs_csr_port_chk
    import ncs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] bus_addr,
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic bus_ack,
    input wire logic bus_err,
    input wire logic int_ack,
    input wire logic [31:0] vector_data,
    input wire ncs_evt_t evt,
    input wire logic tx_poll_pulse,
    input wire logic rx_poll_pulse,
    input wire ncs_proc_t tx_state,
    input wire ncs_proc_t rx_state,
    input wire logic virt_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ack_now_a: assert property (bus_sel && bus_addr[1:0] == 2'h0 |-> bus_ack && !bus_err) else $error("ack");
    align_err_a: assert property (bus_sel && bus_addr[1:0] != 2'h0 |-> bus_err && !bus_ack) else $error("err");
    reset_stop_a: assert property ($fell(reset) |-> tx_state == NCS_STOPPED && rx_state == NCS_STOPPED)
        else $error("rst");
    // a frame alone wakes suspended reception
    frame_wake_a: assert property (rx_state == NCS_SUSPENDED && evt == 8'h02 |=> rx_state == NCS_RUNNING)
        else $error("frame");
    tx_poll_a: assert property (tx_poll_pulse |-> bus_sel && bus_wr && tx_state == NCS_SUSPENDED)
        else $error("txpoll");
    rx_poll_a: assert property (rx_poll_pulse |-> bus_sel && bus_wr && rx_state == NCS_SUSPENDED)
        else $error("rxpoll");
    vec_zero_a: assert property (int_ack |-> vector_data[31:16] == 16'h0 && vector_data[1:0] == 2'h0)
        else $error("vec");
    virt_start_a: assert property ($rose(virt_req) |-> $past(bus_sel)) else $error("virt");
endmodule
bind ncs_csr_port ncs_csr_port_chk chk (.*);
`default_nettype wire

// ===== verification/ncs_virt_proc.sv
`default_nettype none
module ncs_virt_proc (
    input wire logic [3:0] virt_num,
    output logic [31:0] virt_rdata
);
    // pattern tied to the number, so a stale answer shows
    assign virt_rdata = {~virt_num, 24'h3C5A96, virt_num};
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`default_nettype none
module testbench;
    import ncs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset = 1, bus_sel = 0, bus_wr = 0, int_ack = 0, ack, pulse;
    logic [31:0] bus_addr = 0, bus_wdata = 0, bus_rdata, vector_data, virt_wdata, virt_rdata, rd, w;
    logic bus_ack, bus_err, sync_master, tx_poll_pulse, rx_poll_pulse, virt_req, virt_wr;
    logic [4:0] int_level;
    logic [3:0] virt_num;
    ncs_evt_t evt = '0;
    ncs_proc_t tx_state, rx_state;
    int failures = 0, n_compared = 0;
    always #20 clk = ~clk;
    ncs_csr_port dut (.*);
    ncs_virt_proc far (.virt_num(virt_num), .virt_rdata(virt_rdata));
    task automatic print_verdict;
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one access: held from one edge to the next, answer taken in between
    task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_sel <= 1'b1;
        bus_wr <= wr;
        bus_addr <= a;
        bus_wdata <= d;
        #1 rd = bus_rdata;
        ack = bus_ack;
        pulse = tx_poll_pulse | rx_poll_pulse;
        @(posedge clk);
        bus_sel <= 1'b0;
    endtask
    task automatic ev(input ncs_evt_t e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        #1;
    endtask
    // bounded poll on the completion flag
    task automatic wait_done;
        for (int i = 0; i < 700; i++) begin
            acc(1'b0, 32'h14, 32'h0);
            if (rd[DONE_BIT] === 1'b1)
                return;
        end
        failures++;
        print_verdict();
    endtask
    task automatic t_reset;
        acc(1'b1, 32'h0, 32'hFFFFFFFF);
        acc(1'b0, 32'h0, 32'h0);
        check("early write", VEC_PRIO_RESET, rd);
        repeat (20) @(posedge clk);
        acc(1'b0, 32'h14, 32'h0);
        check("init_done", 32'h1, 32'(rd[INIT_DONE_BIT]));
    endtask
    task automatic t_vec;
        for (int p = 0; p < 4; p++) begin
            w = {p[1:0], p[0], 13'h0, 16'h1234 ^ 16'(p)};
            acc(1'b1, 32'h0, w);
            acc(1'b0, 32'h0, 32'h0);
            check("vec rd", (w & VEC_PRIO_WMASK) | (VEC_PRIO_RESET & ~VEC_PRIO_WMASK), rd);
            check("level", 32'(IPL_BASE + 5'(p)), 32'(int_level));
            check("sync", 32'(p[0]), 32'(sync_master));
            @(posedge clk);
            int_ack <= 1'b1;
            #1 check("ack vec", {16'h0, w[15:2], 2'h0}, vector_data);
            @(posedge clk);
            int_ack <= 1'b0;
        end
    endtask
    task automatic t_poll;
        acc(1'b1, 32'h4, 32'hFFFFFFFF);
        check("tx poll stopped", 32'h0, 32'(pulse));
        ev(8'h80);
        ev(8'h20);
        check("tx susp", 32'(NCS_SUSPENDED), 32'(tx_state));
        acc(1'b1, 32'h4, 32'hFFFFFFFE);
        check("tx poll", 32'h1, 32'(pulse));
        #1 check("tx resume", 32'(NCS_RUNNING), 32'(tx_state));
        ev(8'h10);
        ev(8'h04);
        acc(1'b1, 32'h8, 32'hFFFFFFFF);
        check("rx poll", 32'h1, 32'(pulse));
        ev(8'h04);
        ev(8'h02);
        check("rx frame", 32'(NCS_RUNNING), 32'(rx_state));
    endtask
    task automatic t_virt;
        acc(1'b0, 32'h20, 32'h0);
        acc(1'b0, 32'h14, 32'h0);
        check("done low", 32'h0, 32'(rd[DONE_BIT]));
        wait_done();
        acc(1'b0, 32'h20, 32'h0);
        check("virt rd", 32'h73C5A968, rd);
        acc(1'b1, 32'h24, 32'h0BADF00D);
        check("virt ack", 32'h1, 32'(ack));
        wait_done();
        check("virt cap", 32'h0BADF00D, virt_wdata);
        check("virt cap wr", 32'h1, 32'(virt_wr));
        check("virt cap num", 32'h9, 32'(virt_num));
    endtask
    task automatic t_err;
        acc(1'b1, 32'h2, 32'hFFFFFFFF);
        check("misaligned", 32'h0, 32'(ack));
        ev(8'h01);
        acc(1'b0, 32'h14, 32'h0);
        check("parity set", 32'h1, 32'(rd[PARITY_BIT]));
        acc(1'b1, 32'h14, 32'h100);
        acc(1'b0, 32'h14, 32'h0);
        check("parity clr", 32'h0, 32'(rd[PARITY_BIT]));
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_vec();
        t_poll();
        t_virt();
        t_err();
        print_verdict();
    end
endmodule
`default_nettype wire
